/* File: inc/eag_pkg.sv */
// Effective address generator: shared constants and carrier types.
// Assumes the execution unit and bus interface unit share i_clk_sys.
package eag_pkg;

    localparam int EAG_W      = 16;
    localparam int EAG_PHYS_W = 20;
    localparam int EAG_SEG_SH = 4;

    typedef enum logic [3:0] {
        EAG_M_DIRECT,
        EAG_M_REG_IND,
        EAG_M_BASED,
        EAG_M_INDEXED,
        EAG_M_BASED_IDX,
        EAG_M_STR_SRC,
        EAG_M_STR_DST,
        EAG_M_IO_DIRECT,
        EAG_M_IO_IND,
        EAG_M_PTR_FAR
    } eag_mode_t;

    typedef enum logic [1:0] {
        EAG_SEG_EXTRA,
        EAG_SEG_CODE,
        EAG_SEG_STACK,
        EAG_SEG_DATA
    } eag_seg_t;

    typedef enum logic [1:0] {
        EAG_STR_IDLE,
        EAG_STR_RUN
    } eag_str_state_t;

    // Request from the execution unit
    typedef struct packed {
        eag_mode_t         mode;
        logic              base_sel_bp;  // 0 base_register_b, 1 base_pointer
        logic              idx_sel_di;   // 0 source_index, 1 dest_index
        logic [3:0]        gen_sel;      // any general register
        logic              disp16;       // 1: 16-bit displacement
        logic [EAG_W-1:0]  disp;
        logic [7:0]        io_imm;
        logic              ovr_en;
        eag_seg_t          ovr_seg;
        logic              word;         // string element size
        logic              dir_down;     // string direction
        logic [EAG_W-1:0]  ptr_seg;      // far pointer segment base
    } eag_req_t;

    // Answer to the bus interface unit
    typedef struct packed {
        logic [EAG_W-1:0]      ea;
        eag_seg_t              seg;
        logic [EAG_PHYS_W-1:0] phys;
        logic                  io;
    } eag_ans_t;

    localparam logic [EAG_W-1:0] EAG_IO_DIRECT_MAX = 16'h00ff;
    localparam logic [EAG_W-1:0] EAG_STR_MAX_CNT   = 16'hffff;

endpackage : eag_pkg

/* File: src/eag_core.sv */
// Effective address generator: offset, segment and physical address.
// Assumes register file values arrive on i_clk_sys, stable with i_req_vld.
// What this block does
// - Register indirect: effective address is the register, no displacement.
// - Indirect jump_instr or call may source any 16-bit general register.
// - Based: displacement plus base_register_b or base_pointer.
// - base_pointer base selects stack segment unless overridden.
// - Indexed: displacement plus source_index or dest_index.
// - Based-index: base plus index plus displacement.
// - String ops ignore mode fields; source_index source, dest_index destination.
// - Repeated strings step both index registers per element.
// - String source uses data_segment_reg unless overridden, destination always extra_segment_reg.
// - Direct I/O port is the 8-bit immediate, ports 0 to 255.
// - Indirect I/O port comes whole from io_port_pointer.
// - Memory-mapped ports reachable by every memory mode and strings.
// - Strings span one byte up to 64 Kbytes.
// - Pointer is offset alone or segment base plus offset.
// - Memory physical address is shifted segment plus effective address, 20 bits; I/O physical address is the port alone.
// - Effective address is an unsigned 16-bit byte offset.
// - Direct mode uses the displacement alone.
// - Displacement is 8 or 16 bits and constant.
`timescale 1ns/1ps
module eag_core
    import eag_pkg::*;
#(
    parameter int W = EAG_W
)(
    // Clock and reset
    input  wire logic              i_clk_sys,
    input  wire logic              i_nrst,
    // Register file values
    input  wire logic [W-1:0]      i_gen_regs [16],
    input  wire logic [W-1:0]      i_base_register_b,
    input  wire logic [W-1:0]      i_base_pointer,
    input  wire logic [W-1:0]      i_source_index,
    input  wire logic [W-1:0]      i_dest_index,
    input  wire logic [W-1:0]      i_io_port_pointer,
    input  wire logic [W-1:0]      i_count,
    input  wire logic [W-1:0]      i_seg_regs [4],
    // Request
    input  wire logic              i_req_vld,
    input  wire eag_req_t          i_req,
    input  wire logic              i_str_rep,
    input  wire logic              i_str_step,
    // Answer
    output eag_ans_t               o_ans,
    output logic                   o_ans_vld,
    output logic [W-1:0]           o_source_index,
    output logic [W-1:0]           o_dest_index,
    output logic                   o_idx_upd,
    output logic                   o_str_busy
);

    eag_ans_t         ans_r,  ans_nxt;
    logic             vld_r,  vld_nxt;
    logic [W-1:0]     si_r,   si_nxt;
    logic [W-1:0]     di_r,   di_nxt;
    logic             upd_r,  upd_nxt;
    logic [W-1:0]     left_r, left_nxt;
    eag_str_state_t   st_r,   st_nxt;

    logic [W-1:0]     disp_x;
    logic [W-1:0]     base_v;
    logic [W-1:0]     idx_v;
    logic [W-1:0]     si_cur;
    logic [W-1:0]     di_cur;
    logic [W-1:0]     step;
    eag_seg_t         dseg;
    eag_seg_t         seg_v;
    logic [W-1:0]     ea_v;
    logic [W-1:0]     segb;

    always_comb
    begin
        disp_x = i_req.disp16 ? i_req.disp
                              : {{8{i_req.disp[7]}}, i_req.disp[7:0]};
        base_v = i_req.base_sel_bp ? i_base_pointer : i_base_register_b;
        idx_v  = i_req.idx_sel_di ? i_dest_index : i_source_index;
        si_cur = (st_r == EAG_STR_RUN) ? si_r : i_source_index;
        di_cur = (st_r == EAG_STR_RUN) ? di_r : i_dest_index;
        step   = i_req.word ? 16'h0002 : 16'h0001;
        // Stack default only when base_pointer feeds the sum
        // General register 5 is base_pointer itself, so it counts too
        dseg   = ((i_req.base_sel_bp &&
                   (i_req.mode == EAG_M_BASED ||
                    i_req.mode == EAG_M_BASED_IDX)) ||
                  (i_req.mode == EAG_M_REG_IND && i_req.gen_sel == 4'h5))
                 ? EAG_SEG_STACK : EAG_SEG_DATA;
        seg_v  = i_req.ovr_en ? i_req.ovr_seg : dseg;
        ea_v   = '0;
        case (i_req.mode)
            EAG_M_DIRECT:    ea_v = disp_x;
            // Any general register, covers indirect jumps and calls
            EAG_M_REG_IND:   ea_v = i_gen_regs[i_req.gen_sel];
            EAG_M_BASED:     ea_v = W'(base_v + disp_x);
            EAG_M_INDEXED:   ea_v = W'(idx_v + disp_x);
            EAG_M_BASED_IDX: ea_v = W'(base_v + idx_v + disp_x);
            EAG_M_STR_SRC:
            begin
                ea_v  = si_cur;
                seg_v = i_req.ovr_en ? i_req.ovr_seg : EAG_SEG_DATA;
            end
            EAG_M_STR_DST:
            begin
                ea_v  = di_cur;
                seg_v = EAG_SEG_EXTRA;
            end
            EAG_M_IO_DIRECT: ea_v = {8'h00, i_req.io_imm};
            EAG_M_IO_IND:    ea_v = i_io_port_pointer;
            EAG_M_PTR_FAR:   ea_v = disp_x;
            default:         ea_v = disp_x;
        endcase
        // Far pointer carries its own segment base
        segb = (i_req.mode == EAG_M_PTR_FAR) ? i_req.ptr_seg
                                             : i_seg_regs[seg_v];
    end

    always_comb
    begin
        ans_nxt  = ans_r;
        vld_nxt  = i_req_vld;
        si_nxt   = si_r;
        di_nxt   = di_r;
        upd_nxt  = 1'b0;
        left_nxt = left_r;
        st_nxt   = st_r;
        if (i_req_vld)
        begin
            ans_nxt.ea   = ea_v;
            ans_nxt.seg  = seg_v;
            ans_nxt.io   = (i_req.mode == EAG_M_IO_DIRECT) ||
                           (i_req.mode == EAG_M_IO_IND);
            // Memory-mapped ports take the normal memory path
            ans_nxt.phys = ans_nxt.io ? {4'h0, ea_v}
                         : EAG_PHYS_W'({segb, 4'h0} + {4'h0, ea_v});
        end
        case (st_r)
            EAG_STR_IDLE:
                if (i_str_rep && i_count != '0)
                begin
                    si_nxt   = i_source_index;
                    di_nxt   = i_dest_index;
                    left_nxt = i_count;
                    st_nxt   = EAG_STR_RUN;
                end
            EAG_STR_RUN:
                if (i_str_step)
                begin
                    // Pointers wrap inside the segment, 64 Kbytes at most
                    si_nxt   = i_req.dir_down ? W'(si_r - step)
                                              : W'(si_r + step);
                    di_nxt   = i_req.dir_down ? W'(di_r - step)
                                              : W'(di_r + step);
                    upd_nxt  = 1'b1;
                    left_nxt = W'(left_r - 16'h0001);
                    if (left_r == 16'h0001 || !i_str_rep)
                        st_nxt = EAG_STR_IDLE;
                end
            default: st_nxt = EAG_STR_IDLE;
        endcase
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            ans_r  <= '0;
            vld_r  <= 1'b0;
            si_r   <= '0;
            di_r   <= '0;
            upd_r  <= 1'b0;
            left_r <= '0;
            st_r   <= EAG_STR_IDLE;
        end
        else
        begin
            ans_r  <= ans_nxt;
            vld_r  <= vld_nxt;
            si_r   <= si_nxt;
            di_r   <= di_nxt;
            upd_r  <= upd_nxt;
            left_r <= left_nxt;
            st_r   <= st_nxt;
        end
    end

    assign o_ans          = ans_r;
    assign o_ans_vld      = vld_r;
    assign o_source_index = si_r;
    assign o_dest_index   = di_r;
    assign o_idx_upd      = upd_r;
    assign o_str_busy     = (st_r == EAG_STR_RUN);

endmodule : eag_core

/* File: dv/eag_core_chk.sv */
// Port checker for eag_core.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module eag_core_chk
    import eag_pkg::*;
(
    // Clock, reset, register values
    input wire logic             i_clk_sys,
    input wire logic             i_nrst,
    input wire logic [EAG_W-1:0] i_gen_regs [16],
    input wire logic [EAG_W-1:0] i_base_pointer,
    input wire logic [EAG_W-1:0] i_dest_index,
    input wire logic [EAG_W-1:0] i_io_port_pointer,
    input wire logic [EAG_W-1:0] i_seg_regs [4],
    // Request and answer
    input wire logic             i_req_vld,
    input wire eag_req_t         i_req,
    input wire logic             i_str_step,
    input wire eag_ans_t         o_ans,
    input wire logic             o_idx_upd,
    input wire logic             o_str_busy
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_nrst);
    sequence s_req(eag_mode_t m);
        i_req_vld && i_req.mode == m;
    endsequence
    sequence s_step;
        o_str_busy && i_str_step;
    endsequence
    property p_regind;
        s_req(EAG_M_REG_IND) |=>
            o_ans.ea == $past(i_gen_regs[i_req.gen_sel]);
    endproperty
    property p_direct;
        s_req(EAG_M_DIRECT) ##0 i_req.disp16 |=> o_ans.ea == $past(i_req.disp);
    endproperty
    property p_based_ss;
        s_req(EAG_M_BASED) ##0 (i_req.base_sel_bp && i_req.disp16 &&
            !i_req.ovr_en) |=> o_ans.seg == EAG_SEG_STACK &&
            o_ans.ea == $past(i_req.disp + i_base_pointer);
    endproperty
    property p_indexed_ds;
        s_req(EAG_M_INDEXED) ##0 !i_req.ovr_en |=> o_ans.seg == EAG_SEG_DATA
            && o_ans.phys == {$past(i_seg_regs[3]), 4'h0} + o_ans.ea;
    endproperty
    property p_str_dst;
        s_req(EAG_M_STR_DST) ##0 !o_str_busy |=>
            o_ans.ea == $past(i_dest_index) && o_ans.seg == EAG_SEG_EXTRA;
    endproperty
    property p_io_dir;
        s_req(EAG_M_IO_DIRECT) |=>
            o_ans.io && o_ans.ea == {8'h00, $past(i_req.io_imm)};
    endproperty
    property p_io_ind;
        s_req(EAG_M_IO_IND) |=> o_ans.io && o_ans.ea == $past(i_io_port_pointer);
    endproperty
    property p_step;
        s_step |=> o_idx_upd;
    endproperty
    a_regind: assert property (p_regind)
        else $error("register indirect offset wrong");
    a_direct: assert property (p_direct)
        else $error("direct offset wrong");
    a_based_ss: assert property (p_based_ss)
        else $error("based offset or stack segment wrong");
    a_indexed_ds: assert property (p_indexed_ds)
        else $error("indexed segment or physical address wrong");
    a_str_dst: assert property (p_str_dst)
        else $error("string destination wrong");
    a_io_dir: assert property (p_io_dir)
        else $error("direct port wrong");
    a_io_ind: assert property (p_io_ind)
        else $error("indirect port wrong");
    a_step: assert property (p_step)
        else $error("no pointer update after step");
endmodule : eag_core_chk
bind eag_core eag_core_chk eag_core_chk_i (.i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst), .i_gen_regs(i_gen_regs),
    .i_base_pointer(i_base_pointer), .i_dest_index(i_dest_index),
    .i_io_port_pointer(i_io_port_pointer), .i_seg_regs(i_seg_regs),
    .i_req_vld(i_req_vld), .i_req(i_req), .i_str_step(i_str_step),
    .o_ans(o_ans), .o_idx_upd(o_idx_upd), .o_str_busy(o_str_busy));

/* File: dv/eag_biu_model.sv */
// Bus interface model: forms the physical address of an answer.
// Assumes segment values stay steady while an answer stands.
`timescale 1ns/1ps
module eag_biu_model
    import eag_pkg::*;
(
    // Segments and answer
    input  wire logic [EAG_W-1:0] i_seg_regs [4],
    input  wire eag_ans_t         i_ans,
    // Formed address
    output logic [EAG_PHYS_W-1:0] o_phys
);
    // Port space has no segment
    assign o_phys = i_ans.io ? 20'(i_ans.ea) :
        {i_seg_regs[i_ans.seg], 4'h0} + 20'(i_ans.ea);
endmodule : eag_biu_model

/* File: dv/eag_core_test.sv */
// Bench for eag_core: random requests in every mode, string stepping.
// Assumes the package, model and checker are compiled first.
`timescale 1ns/1ps
module eag_core_test;
    import eag_pkg::*;
    logic clk = 0, nrst = 0, vld = 0, rep = 0, step = 0, ans_vld, upd, busy;
    logic [15:0] gr [16], sr [4], bx, bp, si, di, dx, cnt = 0, osi, odi;
    logic [19:0] bphys, ep;
    eag_req_t    req = '0, r;
    eag_ans_t    ans;
    int          n_mismatch = 0, total_checks = 0, seed = 32'h0c0a;
    always #5 clk = ~clk;
    eag_core eag_core_i (.i_clk_sys(clk), .i_nrst(nrst), .i_gen_regs(gr),
        .i_base_register_b(bx), .i_base_pointer(bp), .i_source_index(si),
        .i_dest_index(di), .i_io_port_pointer(dx), .i_count(cnt),
        .i_seg_regs(sr), .i_req_vld(vld), .i_req(req), .i_str_rep(rep),
        .i_str_step(step), .o_ans(ans), .o_ans_vld(ans_vld),
        .o_source_index(osi), .o_dest_index(odi), .o_idx_upd(upd),
        .o_str_busy(busy));
    eag_biu_model eag_biu_model_i (.i_seg_regs(sr), .i_ans(ans),
        .o_phys(bphys));
    function logic [15:0] f_ea(eag_req_t q);
        logic [15:0] d;
        d = q.disp16 ? q.disp : {{8{q.disp[7]}}, q.disp[7:0]};
        case (q.mode)
            EAG_M_REG_IND:   f_ea = gr[q.gen_sel];
            EAG_M_BASED:     f_ea = d + (q.base_sel_bp ? bp : bx);
            EAG_M_INDEXED:   f_ea = d + (q.idx_sel_di ? di : si);
            EAG_M_BASED_IDX: f_ea = d + (q.base_sel_bp ? bp : bx)
                                  + (q.idx_sel_di ? di : si);
            EAG_M_STR_SRC:   f_ea = si;
            EAG_M_STR_DST:   f_ea = di;
            EAG_M_IO_DIRECT: f_ea = {8'h00, q.io_imm};
            EAG_M_IO_IND:    f_ea = dx;
            default:         f_ea = d;
        endcase
    endfunction : f_ea
    function eag_seg_t f_seg(eag_req_t q);
        if (q.mode == EAG_M_STR_DST) f_seg = EAG_SEG_EXTRA;
        else if (q.ovr_en) f_seg = q.ovr_seg;
        else if ((q.mode inside {EAG_M_BASED, EAG_M_BASED_IDX} && q.base_sel_bp)
            || (q.mode == EAG_M_REG_IND && q.gen_sel == 4'h5))
            f_seg = EAG_SEG_STACK;
        else f_seg = EAG_SEG_DATA;
    endfunction : f_seg
    task chk(input string nm, input logic [19:0] e, input logic [19:0] g);
        total_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task complete_run;
        $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : complete_run
    initial
    begin
        #50000 n_mismatch++;
        complete_run();
    end
    initial
    begin
        repeat (3) @(posedge clk);
        #1 chk("reset", 20'h0, 20'({ans_vld, upd, busy}));
        nrst = 1;
        for (int i = 0; i < 200; i++)
        begin
            foreach (gr[k]) gr[k] = 16'($random(seed));
            foreach (sr[k]) sr[k] = 16'($random(seed));
            {bx, bp, si, di, dx} = 80'({$random(seed), $random(seed),
                $random(seed)});
            r = eag_req_t'(56'({$random(seed), $random(seed)}));
            r.mode = eag_mode_t'(i % 10);
            if (i < 20) r.disp = 16'hffff;
            if (r.mode == EAG_M_PTR_FAR) r.disp16 = 1;
            ep = r.mode == EAG_M_PTR_FAR ? {r.ptr_seg, 4'h0} + r.disp :
                {sr[f_seg(r)], 4'h0} + f_ea(r);
            if (r.mode inside {EAG_M_IO_DIRECT, EAG_M_IO_IND}) ep = f_ea(r);
            req = r;
            vld = 1;
            @(posedge clk);
            #1 vld = 0;
            chk("ans_vld", 20'h1, 20'(ans_vld));
            chk("ea", f_ea(r), ans.ea);
            chk("phys", ep, ans.phys);
            chk("io", r.mode inside {EAG_M_IO_DIRECT, EAG_M_IO_IND}, ans.io);
            if (!ans.io && r.mode != EAG_M_PTR_FAR)
            begin
                chk("seg", f_seg(r), ans.seg);
                chk("biu", ep, bphys);
            end
            @(posedge clk);
            #1;
        end
        si = 16'hfffe;
        di = 16'h7ff0;
        cnt = 3;
        req.word = 1;
        req.dir_down = 0;
        rep = 1;
        for (int k = 1; k <= 3; k++)
        begin
            @(posedge clk);
            #1 step = 1;
            @(posedge clk);
            #1 step = 0;
            chk("src", 16'(16'hfffe + 2 * k), osi);
            chk("dst", 16'(16'h7ff0 + 2 * k), odi);
            chk("upd", 20'h1, 20'(upd));
        end
        rep = 0;
        repeat (2) @(posedge clk);
        #1 chk("busy", 20'h0, 20'(busy));
        complete_run();
    end
endmodule : eag_core_test
